// ==== hw/iex_pkg.sv ====
// constants and types shared by the expander serial slave front end
package iex_pkg;

    // fixed upper four bits of the seven-bit slave address
    localparam logic [3:0] ADDR_PREFIX   = 4'h3;
    localparam int         ASEL_W        = 3;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic       DIR_READ      = 1'h1;

    // command pointer encodings in the two low bits of the command byte
    localparam logic [1:0] PTR_INPUT     = 2'h0;
    localparam logic [1:0] PTR_OUTPUT    = 2'h1;
    localparam logic [1:0] PTR_POLARITY  = 2'h2;
    localparam logic [1:0] PTR_CONFIG    = 2'h3;
    localparam logic [1:0] PTR_RESET     = 2'h0;

    // direction mirror: 1 means the port line is an input
    localparam logic [7:0] DIR_RESET     = 8'hff;

    // written bytes leave through the fifo as {pointer, data}
    localparam int         FIFO_WIDTH    = 10;
    localparam int         FIFO_DEPTH    = 16;

    // gray codes along idle, address, ack, receive, ack, transmit, master ack
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_RX       = 3'h2,
        ST_RX_ACK   = 3'h6,
        ST_TX       = 3'h7,
        ST_TX_ACK   = 3'h5
    } iex_state_t;

endpackage : iex_pkg

// ==== hw/iex_fifo.sv ====
// parameterised fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module iex_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // draining side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int         AW   = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    // head and nonempty are kept as flops so the draining side sees no logic path
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            head;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 count;
        logic                        nonempty;
    } iex_fifo_q_t;

    iex_fifo_q_t q;
    iex_fifo_q_t n;
    logic        push;
    logic        pop;

    assign in_ready  = (q.count != FULL);
    assign out_valid = q.nonempty;
    assign out_data  = q.head;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        n = q;
        if (push)
        begin
            n.mem[q.wp] = in_data;
            n.wp        = q.wp + 1'b1;
        end
        if (pop)
            n.rp = q.rp + 1'b1;
        if (push && !pop)
            n.count = q.count + 1'b1;
        else if (pop && !push)
            n.count = q.count - 1'b1;
        n.nonempty = (n.count != '0);
        n.head     = n.mem[n.rp];
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= n;
    end

    a_fifo_fill: assert property (@(posedge mclk) disable iff (!resetn)
        (push && !pop) |=> (q.count == $past(q.count) + 1'b1))
        else $error("fifo count did not rise on a lone push");
    a_fifo_full: assert property (@(posedge mclk) disable iff (!resetn)
        (q.count == FULL) |-> (!in_ready && out_valid))
        else $error("full fifo still ready or not valid");
    a_fifo_empty: assert property (@(posedge mclk) disable iff (!resetn)
        (q.count == '0) |-> (!out_valid && in_ready))
        else $error("empty fifo still valid or not ready");

endmodule : iex_fifo
`default_nettype wire

// ==== hw/iex_slave.sv ====
// two-wire serial slave front end of the eight-bit port expander
`timescale 1ns/1ps
`default_nettype none

module iex_slave #(
    parameter int FIFO_W = iex_pkg::FIFO_WIDTH,
    parameter int FIFO_D = iex_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic                     supply_ok,
    // serial bus pins
    input  wire logic                     scl,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_n,
    input  wire logic [iex_pkg::ASEL_W-1:0] address_select_pins,
    // register side
    output logic                          command_select_high,
    output logic                          command_select_low,
    output logic [7:0]                    port_input_dir,
    output logic                          bus_busy,
    output logic                          rd_strobe,
    input  wire logic [7:0]               rd_data,
    // written bytes leaving through the fifo
    output logic                          wr_valid,
    output logic [7:0]                    wr_data,
    output logic [1:0]                    wr_ptr,
    input  wire logic                     wr_ready
);

    typedef struct packed {
        logic                           scl_m;
        logic                           scl_s;
        logic                           scl_d;
        logic                           sda_m;
        logic                           sda_s;
        logic                           sda_d;
        logic [iex_pkg::ASEL_W-1:0]     asel_m;
        logic [iex_pkg::ASEL_W-1:0]     asel_s;
        logic                           por_m;
        logic                           por_s;
        iex_pkg::iex_state_t            state;
        logic [3:0]                     bitcnt;
        logic [7:0]                     shift;
        logic                           rw;
        logic                           first_byte;
        logic                           ack;
        logic [1:0]                     ptr;
        logic [7:0]                     dir;
        logic                           sda_oe_n;
        logic                           busy;
        logic                           push;
        logic [FIFO_W-1:0]              push_data;
        logic                           rd_strobe;
    } iex_slave_q_t;

    // idle bus levels avoid a false start or stop at release
    localparam iex_slave_q_t Q_RST = '{
        scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
        sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
        asel_m: '0, asel_s: '0, por_m: 1'b0, por_s: 1'b0,
        state: iex_pkg::ST_IDLE, bitcnt: '0, shift: '0,
        rw: 1'b0, first_byte: 1'b0, ack: 1'b0,
        ptr: iex_pkg::PTR_RESET, dir: iex_pkg::DIR_RESET,
        sda_oe_n: 1'b1, busy: 1'b0, push: 1'b0, push_data: '0,
        rd_strobe: 1'b0
    };

    iex_slave_q_t q;
    iex_slave_q_t n;
    logic         fifo_ready;
    logic         start_ev;
    logic         stop_ev;
    logic         scl_rise;
    logic         scl_fall;
    logic         byte_done;

    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [iex_pkg::ASEL_W-1:0] sel);
        addr_match = (b[7:1] == {iex_pkg::ADDR_PREFIX, sel});
    endfunction : addr_match

    // events look only at the second and third sync stages
    assign start_ev  = q.scl_s && q.scl_d && q.sda_d && !q.sda_s;
    assign stop_ev   = q.scl_s && q.scl_d && !q.sda_d && q.sda_s;
    assign scl_rise  = q.scl_s && !q.scl_d;
    assign scl_fall  = !q.scl_s && q.scl_d;
    assign byte_done = scl_fall && (q.bitcnt == iex_pkg::BYTE_BITS);

    always_comb
    begin
        n           = q;
        n.scl_m     = scl;
        n.scl_s     = q.scl_m;
        n.scl_d     = q.scl_s;
        n.sda_m     = sda_in;
        n.sda_s     = q.sda_m;
        n.sda_d     = q.sda_s;
        n.asel_m    = address_select_pins;
        n.asel_s    = q.asel_m;
        n.por_m     = supply_ok;
        n.por_s     = q.por_m;
        n.push      = 1'b0;
        n.rd_strobe = 1'b0;
        if (!q.por_s)
        begin
            n.state      = iex_pkg::ST_IDLE;
            n.bitcnt     = '0;
            n.shift      = '0;
            n.rw         = 1'b0;
            n.first_byte = 1'b0;
            n.ack        = 1'b0;
            n.ptr        = iex_pkg::PTR_RESET;
            n.dir        = iex_pkg::DIR_RESET;
            n.sda_oe_n   = 1'b1;
            n.busy       = 1'b0;
        end
        else if (start_ev)
        begin
            // repeated start lands here too; pointer survives
            n.state    = iex_pkg::ST_ADDR;
            n.bitcnt   = '0;
            n.sda_oe_n = 1'b1;
            n.busy     = 1'b1;
        end
        else if (stop_ev)
        begin
            n.state    = iex_pkg::ST_IDLE;
            n.sda_oe_n = 1'b1;
            n.busy     = 1'b0;
        end
        else
        begin
            case (q.state)
                iex_pkg::ST_IDLE:
                begin
                    n.sda_oe_n = 1'b1;
                end
                iex_pkg::ST_ADDR, iex_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        n.shift  = {q.shift[6:0], q.sda_s};
                        n.bitcnt = q.bitcnt + 4'h1;
                    end
                    else if (byte_done && q.state == iex_pkg::ST_ADDR)
                    begin
                        if (addr_match(q.shift, q.asel_s))
                        begin
                            n.state    = iex_pkg::ST_ADDR_ACK;
                            n.rw       = q.shift[0];
                            n.sda_oe_n = 1'b0;
                        end
                        else
                        begin
                            // not ours: stay silent until the next start
                            n.state = iex_pkg::ST_IDLE;
                        end
                    end
                    else if (byte_done)
                    begin
                        n.state = iex_pkg::ST_RX_ACK;
                        if (q.first_byte)
                        begin
                            n.ptr        = q.shift[1:0];
                            n.first_byte = 1'b0;
                            n.ack        = 1'b1;
                        end
                        else if (fifo_ready)
                        begin
                            // full fifo is refused with a nack, never overwritten
                            n.push      = 1'b1;
                            n.push_data = {q.ptr, q.shift};
                            n.ack       = 1'b1;
                            if (q.ptr == iex_pkg::PTR_CONFIG)
                                n.dir = q.shift;
                        end
                        else
                            n.ack = 1'b0;
                        n.sda_oe_n = !n.ack;
                    end
                end
                iex_pkg::ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        n.bitcnt = '0;
                        if (q.rw == iex_pkg::DIR_READ)
                        begin
                            n.state     = iex_pkg::ST_TX;
                            n.shift     = {rd_data[6:0], 1'b0};
                            n.sda_oe_n  = rd_data[7];
                            n.bitcnt    = 4'h1;
                            n.rd_strobe = 1'b1;
                        end
                        else
                        begin
                            n.state      = iex_pkg::ST_RX;
                            n.first_byte = 1'b1;
                            n.sda_oe_n   = 1'b1;
                        end
                    end
                end
                iex_pkg::ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        n.state    = iex_pkg::ST_RX;
                        n.bitcnt   = '0;
                        n.sda_oe_n = 1'b1;
                    end
                end
                iex_pkg::ST_TX:
                begin
                    if (byte_done)
                    begin
                        n.state    = iex_pkg::ST_TX_ACK;
                        n.sda_oe_n = 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        n.sda_oe_n = q.shift[7];
                        n.shift    = {q.shift[6:0], 1'b0};
                        n.bitcnt   = q.bitcnt + 4'h1;
                    end
                end
                iex_pkg::ST_TX_ACK:
                begin
                    if (scl_rise)
                        n.ack = !q.sda_s;
                    else if (scl_fall && q.ack)
                    begin
                        n.state     = iex_pkg::ST_TX;
                        n.shift     = {rd_data[6:0], 1'b0};
                        n.sda_oe_n  = rd_data[7];
                        n.bitcnt    = 4'h1;
                        n.rd_strobe = 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        n.state    = iex_pkg::ST_IDLE;
                        n.sda_oe_n = 1'b1;
                    end
                end
                default:
                begin
                    n.state    = iex_pkg::ST_IDLE;
                    n.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            q <= Q_RST;
        else
            q <= n;
    end

    iex_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (q.push),
        .in_data   (q.push_data),
        .in_ready  (fifo_ready),
        .out_valid (wr_valid),
        .out_data  ({wr_ptr, wr_data}),
        .out_ready (wr_ready)
    );

    assign sda_out             = 1'b0;
    assign sda_oe_n            = q.sda_oe_n;
    assign command_select_high = q.ptr[1];
    assign command_select_low  = q.ptr[0];
    assign port_input_dir      = q.dir;
    assign bus_busy            = q.busy;
    assign rd_strobe           = q.rd_strobe;

    a_ack_addr_low: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (q.state == iex_pkg::ST_ADDR_ACK) |-> !q.sda_oe_n)
        else $error("address ack not driven low");
    a_start_restart: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        start_ev |=> (q.state == iex_pkg::ST_ADDR && q.bitcnt == 4'h0 && q.busy))
        else $error("start did not restart address reception");
    a_stop_idle: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (stop_ev && !start_ev) |=> (q.state == iex_pkg::ST_IDLE && q.sda_oe_n && !q.busy))
        else $error("stop did not return to idle with sda released");
    a_dir_reset: assert property (
        @(posedge mclk) disable iff (!resetn)
        !q.por_s |=> (q.dir == iex_pkg::DIR_RESET && q.ptr == iex_pkg::PTR_RESET))
        else $error("power-on reset left a port line as output");
    a_ptr_hold: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (q.state != iex_pkg::ST_RX || !q.first_byte) |=> $stable(q.ptr))
        else $error("pointer changed outside a command byte");
    a_tx_release: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (q.state == iex_pkg::ST_TX && byte_done && !start_ev && !stop_ev)
            |=> (q.state == iex_pkg::ST_TX_ACK && q.sda_oe_n))
        else $error("transmitter kept sda in the ack slot");
    a_nack_release: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (q.state == iex_pkg::ST_TX_ACK && !q.ack && scl_fall && !start_ev)
            |=> (q.state == iex_pkg::ST_IDLE && q.sda_oe_n))
        else $error("sda not released after master nack");
    a_rx_ack_low: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (q.state == iex_pkg::ST_RX_ACK) |-> (q.sda_oe_n == !q.ack))
        else $error("receive ack level wrong");
    a_idle_quiet: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (q.state == iex_pkg::ST_IDLE) |-> q.sda_oe_n)
        else $error("sda driven while not addressed");
    a_bit_count: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (scl_rise && q.state == iex_pkg::ST_ADDR && !start_ev && !stop_ev)
            |=> (q.bitcnt == $past(q.bitcnt) + 4'h1))
        else $error("bit count did not step once per pulse");
    a_sda_steady: assert property (
        @(posedge mclk) disable iff (!resetn || !q.por_s)
        (q.scl_s && q.scl_d && !start_ev && !stop_ev) |=> $stable(q.sda_oe_n))
        else $error("device moved sda while scl high");

endmodule : iex_slave
`default_nettype wire

// ==== tb/iex_master.sv ====
// behavioural two-wire bus master: scl and an open-drain pull on sda
`timescale 1ns/1ps
`default_nettype none

module iex_master (
    // clock
    input  wire logic mclk,
    // bus
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // free bus: scl driven high, sda released so the pull-up sets it high
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask : wt

    // a start is only begun from a free bus or a low clock, which also gives a restart
    task automatic start();
        wt(1);
        sda_low = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(2);
        sda_low = 1'b1;
        wt(2);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        wt(1);
        sda_low = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(2);
        sda_low = 1'b0;
        wt(4);
    endtask : stop

    // data moves only while scl is low; 5 low plus 3 high makes 800 ns
    task automatic bit_xfer(input logic b, output logic seen);
        wt(1);
        sda_low = ~b;
        wt(4);
        scl = 1'b1;
        wt(2);
        seen = sda;
        wt(1);
        scl = 1'b0;
    endtask : bit_xfer

    // tx of ff releases sda so the device can drive; ack_in 0 acks, 1 does not
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                             output logic [7:0] rx, output logic ack_seen);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(tx[i], s);
            rx[i] = s;
        end
        bit_xfer(ack_in, s);
        ack_seen = ~s;
    endtask : xfer_byte
endmodule : iex_master

`default_nettype wire

// ==== tb/iex_slave_tb.sv ====
// self-checking bench of the expander serial slave front end
`timescale 1ns/1ps
`default_nettype none

module iex_slave_tb;
    logic                         mclk;
    logic                         resetn;
    logic                         supply_ok;
    logic                         scl;
    logic                         sda_low;
    logic                         sda_out;
    logic                         sda_oe_n;
    logic [iex_pkg::ASEL_W-1:0]   asel;
    logic                         command_select_high;
    logic                         command_select_low;
    logic [7:0]                   port_input_dir;
    logic                         bus_busy;
    logic                         rd_strobe;
    logic [7:0]                   rd_data = 8'h5a;
    logic                         wr_valid;
    logic [7:0]                   wr_data;
    logic [1:0]                   wr_ptr;
    logic                         wr_ready;
    logic [7:0]                   rx;
    logic                         ack;
    logic [9:0]                   exp_q[$];
    logic [7:0]                   rd_q[$];
    logic [7:0]                   dir;
    int                           n_errors = 0;
    int                           samples_checked = 0;
    int                           seed = 32'hde4bae5a;
    // pull-up line, low when either party pulls
    wire logic sda_line = (sda_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;

    iex_slave uut (.mclk(mclk), .resetn(resetn), .supply_ok(supply_ok), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_select_pins(asel), .command_select_high(command_select_high),
        .command_select_low(command_select_low), .port_input_dir(port_input_dir),
        .bus_busy(bus_busy), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_ptr(wr_ptr), .wr_ready(wr_ready));
    iex_master m (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda_line));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // register model: the value held when a byte loads is what must come out
    always @(negedge mclk)
        if (rd_strobe === 1'b1)
        begin
            rd_q.push_back(rd_data);
            rd_data = 8'($random(seed));
        end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset(input logic por);
        if (por)
            supply_ok = 1'b0;
        else
            resetn = 1'b0;
        repeat (12) @(negedge mclk);
        check({command_select_high, command_select_low, port_input_dir, sda_oe_n, bus_busy},
              {2'h0, 8'hff, 1'h1, 1'h0});
        supply_ok = 1'b1;
        resetn = 1'b1;
        dir = 8'hff;
        repeat (6) @(negedge mclk);
        $display("reset test done");
    endtask : do_reset

    // address, pointer, n bytes; only the first n_ok fit and are acked
    task automatic wr_txn(input logic [1:0] p, input int n, input int n_ok);
        logic [7:0] d;
        m.start();
        m.xfer_byte({iex_pkg::ADDR_PREFIX, asel, 1'b0}, 1'b1, rx, ack);
        check(ack, 1'b1);
        m.xfer_byte({6'h0, p}, 1'b1, rx, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            m.xfer_byte(d, 1'b1, rx, ack);
            check(ack, i < n_ok);
            if (i < n_ok)
                exp_q.push_back({p, d});
            if (i < n_ok && p == iex_pkg::PTR_CONFIG)
                dir = d;
        end
        m.stop();
        check({command_select_high, command_select_low, port_input_dir, bus_busy},
              {p, dir, 1'b0});
        $display("write test done");
    endtask : wr_txn

    // one idle cycle between pops stalls the consumer side
    task automatic drain(input int n);
        for (int k = 0; k < n; k++)
        begin
            int w;
            for (w = 0; w < 50 && wr_valid !== 1'b1; w++) @(negedge mclk);
            if (w == 50)
            begin
                n_errors++;
                print_verdict();
            end
            check({wr_ptr, wr_data}, exp_q.pop_front());
            wr_ready = 1'b1;
            @(negedge mclk);
            wr_ready = 1'b0;
            @(negedge mclk);
        end
        check(wr_valid, 1'b0);
        $display("drain test done");
    endtask : drain

    task automatic rd_txn(input logic cmd, input logic [1:0] p, input int n);
        m.start();
        if (cmd)
        begin
            m.xfer_byte({iex_pkg::ADDR_PREFIX, asel, 1'b0}, 1'b1, rx, ack);
            m.xfer_byte({6'h0, p}, 1'b1, rx, ack);
            m.start();
        end
        m.xfer_byte({iex_pkg::ADDR_PREFIX, asel, iex_pkg::DIR_READ}, 1'b1, rx, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            m.xfer_byte(8'hff, i == n - 1, rx, ack);
            check(rx, rd_q.pop_front());
        end
        m.stop();
        check(16'(rd_q.size()), 16'h0);
        check({command_select_high, command_select_low, sda_oe_n}, {p, 1'b1});
        $display("read test done");
    endtask : rd_txn

    initial
    begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        resetn = 1'b0;
        supply_ok = 1'b1;
        wr_ready = 1'b0;
        asel = 3'h0;
        do_reset(1'b0);
        for (int a = 0; a < 8; a++)
        begin
            asel = 3'($random(seed));
            m.start();
            m.xfer_byte({iex_pkg::ADDR_PREFIX, 3'(a), 1'b0}, 1'b1, rx, ack);
            check(ack, 3'(a) == asel);
            check(bus_busy, 1'b1);
            m.stop();
        end
        m.start();
        m.xfer_byte({4'h2, asel, 1'b0}, 1'b1, rx, ack);
        check(ack, 1'b0);
        m.start();
        for (int b = 0; b < 3; b++) m.bit_xfer(1'b0, ack);
        m.start();
        m.xfer_byte({iex_pkg::ADDR_PREFIX, asel, 1'b0}, 1'b1, rx, ack);
        check(ack, 1'b1);
        m.stop();
        $display("address test done");
        for (int p = 0; p < 4; p++) wr_txn(2'(p), 2, 2);
        drain(8);
        wr_txn(iex_pkg::PTR_OUTPUT, 17, 16);
        drain(16);
        rd_txn(1'b1, iex_pkg::PTR_POLARITY, 3);
        rd_txn(1'b0, iex_pkg::PTR_POLARITY, 2);
        wr_txn(iex_pkg::PTR_CONFIG, 1, 1);
        drain(1);
        do_reset(1'b1);
        wr_txn(iex_pkg::PTR_CONFIG, 1, 1);
        drain(1);
        do_reset(1'b0);
        print_verdict();
    end
endmodule : iex_slave_tb

`default_nettype wire
